// ==== trtu_timer_unit.sv ====
// trtu_timer_unit: three down-counting reload timers sharing one tick prescaler,
// with their registers behind a word-only peripheral request port.
// assumes requests synchronous to clk, one per cycle, answered one cycle later.
`timescale 1ns/10ps
`default_nettype none

module trtu_timer_unit (
	input  wire logic                                clk,
	input  wire logic                                reset,
	input  wire logic [trtu_pkg::BASE_HI_W-1:0]      base_addr_hi,
	input  wire trtu_pkg::trtu_req_t                 req,
	output trtu_pkg::trtu_rsp_t                      rsp,
	output logic [trtu_pkg::NUM_TIMERS-1:0]          timer_irq
);

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic trtu_pkg::trtu_dec_t decode(input logic [trtu_pkg::OFF_W-1:0] off);
		trtu_pkg::trtu_dec_t d;
		d.kind  = trtu_pkg::KIND_NONE;
		d.timer = trtu_pkg::IDX_TIMER0;
		case (off)
			trtu_pkg::OFF_TIMER0_RELOAD: begin
				d = '{trtu_pkg::KIND_RELOAD, trtu_pkg::IDX_TIMER0};
			end
			trtu_pkg::OFF_TIMER0_COUNT: begin
				d = '{trtu_pkg::KIND_COUNT, trtu_pkg::IDX_TIMER0};
			end
			trtu_pkg::OFF_TIMER0_CONTROL: begin
				d = '{trtu_pkg::KIND_CONTROL, trtu_pkg::IDX_TIMER0};
			end
			trtu_pkg::OFF_TIMER1_RELOAD: begin
				d = '{trtu_pkg::KIND_RELOAD, trtu_pkg::IDX_TIMER1};
			end
			trtu_pkg::OFF_TIMER1_COUNT: begin
				d = '{trtu_pkg::KIND_COUNT, trtu_pkg::IDX_TIMER1};
			end
			trtu_pkg::OFF_TIMER1_CONTROL: begin
				d = '{trtu_pkg::KIND_CONTROL, trtu_pkg::IDX_TIMER1};
			end
			trtu_pkg::OFF_TIMER2_RELOAD: begin
				d = '{trtu_pkg::KIND_RELOAD, trtu_pkg::IDX_TIMER2};
			end
			trtu_pkg::OFF_TIMER2_COUNT: begin
				d = '{trtu_pkg::KIND_COUNT, trtu_pkg::IDX_TIMER2};
			end
			trtu_pkg::OFF_TIMER2_CONTROL: begin
				d = '{trtu_pkg::KIND_CONTROL, trtu_pkg::IDX_TIMER2};
			end
			trtu_pkg::OFF_TICK_PRESCALER: begin
				d = '{trtu_pkg::KIND_PRESCALER, trtu_pkg::IDX_TIMER0};
			end
			default: begin
				d.kind = trtu_pkg::KIND_NONE;
			end
		endcase
		return d;
	endfunction

	// true when this cycle writes register kind k of timer i
	function automatic logic hits(
		input logic                          wr,
		input trtu_pkg::trtu_dec_t           d,
		input trtu_pkg::trtu_kind_t          k,
		input int                            i
	);
		return wr && (d.kind == k) && (d.timer == trtu_pkg::IDX_W'(i));
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [trtu_pkg::DATA_W-1:0]     count        [trtu_pkg::NUM_TIMERS];
	logic [trtu_pkg::DATA_W-1:0]     reload       [trtu_pkg::NUM_TIMERS];
	logic [trtu_pkg::NUM_TIMERS-1:0] enable;
	logic [trtu_pkg::NUM_TIMERS-1:0] irq_enable;
	logic [trtu_pkg::NUM_TIMERS-1:0] status;
	logic [trtu_pkg::DIV_W-1:0]      div_value;
	logic [trtu_pkg::DIV_W-1:0]      div_count;

	logic [trtu_pkg::NUM_TIMERS-1:0] next_enable;
	logic [trtu_pkg::NUM_TIMERS-1:0] next_irq_enable;
	logic [trtu_pkg::NUM_TIMERS-1:0] next_status;
	logic [trtu_pkg::NUM_TIMERS-1:0] expire;
	logic [trtu_pkg::DATA_W-1:0]     read_word;

	trtu_pkg::trtu_dec_t dec;
	logic                base_hit;
	logic                legal;
	logic                wr;
	logic                tick;

	// ------------------------------------------------------------
	// request decode
	// ------------------------------------------------------------
	assign dec      = decode(req.addr[trtu_pkg::OFF_W-1:0]);
	// base pins feed the compare directly, no register in between
	assign base_hit = req.addr[trtu_pkg::ADDR_W-1:trtu_pkg::OFF_W] == base_addr_hi;
	// exact offset match also rejects misaligned words
	assign legal    = req.valid && base_hit && (dec.kind != trtu_pkg::KIND_NONE)
		&& (req.size == trtu_pkg::SIZE_WORD);
	assign wr       = legal && req.write;

	// ------------------------------------------------------------
	// shared prescaler
	// ------------------------------------------------------------
	// >= rather than == so a smaller value written mid-period
	// cannot leave the counter running the long way round
	assign tick = div_count >= div_value;

	always_ff @(posedge clk) begin
		if (reset) begin
			div_value <= trtu_pkg::RESET_DIV;
		end else if (wr && dec.kind == trtu_pkg::KIND_PRESCALER) begin
			div_value <= req.wdata[trtu_pkg::DIV_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			div_count <= trtu_pkg::RESET_DIV;
		end else if (tick) begin
			div_count <= trtu_pkg::RESET_DIV;
		end else begin
			div_count <= div_count + trtu_pkg::DIV_STEP;
		end
	end

	// ------------------------------------------------------------
	// counters and reload values
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < trtu_pkg::NUM_TIMERS; i++) begin
			expire[i] = enable[i] && tick && (count[i] == trtu_pkg::RESET_WORD);
		end
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < trtu_pkg::NUM_TIMERS; i++) begin
			if (reset) begin
				count[i] <= trtu_pkg::RESET_WORD;
			end else if (hits(wr, dec, trtu_pkg::KIND_COUNT, i)) begin
				count[i] <= req.wdata;
			end else if (expire[i]) begin
				count[i] <= reload[i];
			end else if (enable[i] && tick) begin
				count[i] <= count[i] - trtu_pkg::COUNT_STEP;
			end
		end
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < trtu_pkg::NUM_TIMERS; i++) begin
			if (reset) begin
				reload[i] <= trtu_pkg::RESET_WORD;
			end else if (hits(wr, dec, trtu_pkg::KIND_RELOAD, i)) begin
				reload[i] <= req.wdata;
			end
		end
	end

	// ------------------------------------------------------------
	// control and status
	// ------------------------------------------------------------
	always_comb begin
		next_enable     = enable;
		next_irq_enable = irq_enable;
		next_status     = status;
		for (int i = 0; i < trtu_pkg::NUM_TIMERS; i++) begin
			if (hits(wr, dec, trtu_pkg::KIND_CONTROL, i)) begin
				next_enable[i]     = req.wdata[trtu_pkg::CTRL_ENABLE_BIT];
				next_irq_enable[i] = req.wdata[trtu_pkg::CTRL_IRQ_EN_BIT];
				if (req.wdata[trtu_pkg::CTRL_STATUS_BIT]) begin
					next_status[i] = 1'b0;
				end
			end
			// placed after the clear so a coincident expiry wins
			if (expire[i]) begin
				next_status[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			enable     <= '0;
			irq_enable <= '0;
			status     <= '0;
		end else begin
			enable     <= next_enable;
			irq_enable <= next_irq_enable;
			status     <= next_status;
		end
	end

	// registered from next values so the line tracks status & irq_enable with no lag
	always_ff @(posedge clk) begin
		if (reset) begin
			timer_irq <= '0;
		end else begin
			timer_irq <= next_status & next_irq_enable;
		end
	end

	// ------------------------------------------------------------
	// read data and answer
	// ------------------------------------------------------------
	always_comb begin
		read_word = trtu_pkg::RESET_WORD;
		unique case (dec.kind)
			trtu_pkg::KIND_RELOAD: begin
				read_word = reload[dec.timer];
			end
			trtu_pkg::KIND_COUNT: begin
				read_word = count[dec.timer];
			end
			trtu_pkg::KIND_CONTROL: begin
				read_word[trtu_pkg::CTRL_ENABLE_BIT] = enable[dec.timer];
				read_word[trtu_pkg::CTRL_IRQ_EN_BIT] = irq_enable[dec.timer];
				read_word[trtu_pkg::CTRL_STATUS_BIT] = status[dec.timer];
			end
			trtu_pkg::KIND_PRESCALER: begin
				read_word[trtu_pkg::DIV_W-1:0] = div_value;
			end
			trtu_pkg::KIND_NONE: begin
				read_word = trtu_pkg::RESET_WORD;
			end
		endcase
	end

	// every request is answered one cycle later; writes already took effect
	always_ff @(posedge clk) begin
		if (reset) begin
			rsp <= '0;
		end else begin
			rsp.ack   <= req.valid;
			rsp.err   <= req.valid && !legal;
			rsp.rdata <= (legal && !req.write) ? read_word : trtu_pkg::RESET_WORD;
		end
	end

endmodule

`default_nettype wire

// ==== trtu_pkg.sv ====
// trtu_pkg: constants, types and register map of the triple reload timer unit.
// assumes a word-only peripheral request port and a single bus clock.
`default_nettype none

package trtu_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int NUM_TIMERS = 3;
	localparam int DATA_W     = 32;
	localparam int ADDR_W     = 32;
	localparam int BASE_HI_W  = 12;
	localparam int OFF_W      = 20;
	localparam int DIV_W      = 16;
	localparam int IDX_W      = 2;

	// ------------------------------------------------------------
	// register offsets from the peripheral base
	// ------------------------------------------------------------
	localparam logic [OFF_W-1:0] OFF_TIMER0_RELOAD  = 20'h0_0200;
	localparam logic [OFF_W-1:0] OFF_TIMER0_COUNT   = 20'h0_0208;
	localparam logic [OFF_W-1:0] OFF_TIMER0_CONTROL = 20'h0_0210;
	localparam logic [OFF_W-1:0] OFF_TIMER1_RELOAD  = 20'h0_0218;
	localparam logic [OFF_W-1:0] OFF_TIMER1_COUNT   = 20'h0_0220;
	localparam logic [OFF_W-1:0] OFF_TIMER1_CONTROL = 20'h0_0228;
	localparam logic [OFF_W-1:0] OFF_TIMER2_RELOAD  = 20'h0_0230;
	localparam logic [OFF_W-1:0] OFF_TIMER2_COUNT   = 20'h0_0238;
	localparam logic [OFF_W-1:0] OFF_TIMER2_CONTROL = 20'h0_0240;
	localparam logic [OFF_W-1:0] OFF_TICK_PRESCALER = 20'h0_0248;

	localparam logic [IDX_W-1:0] IDX_TIMER0 = 2'h0;
	localparam logic [IDX_W-1:0] IDX_TIMER1 = 2'h1;
	localparam logic [IDX_W-1:0] IDX_TIMER2 = 2'h2;

	// ------------------------------------------------------------
	// control fields, transfer size, reset values
	// ------------------------------------------------------------
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_IRQ_EN_BIT = 1;
	localparam int CTRL_STATUS_BIT = 2;

	localparam logic [1:0] SIZE_WORD = 2'h2;

	localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
	localparam logic [DIV_W-1:0]  RESET_DIV  = 16'h0000;
	localparam logic [DIV_W-1:0]  DIV_STEP   = 16'h0001;
	localparam logic [DATA_W-1:0] COUNT_STEP = 32'h0000_0001;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		KIND_NONE      = 3'b000,
		KIND_RELOAD    = 3'b001,
		KIND_COUNT     = 3'b010,
		KIND_CONTROL   = 3'b011,
		KIND_PRESCALER = 3'b100
	} trtu_kind_t;

	typedef struct packed {
		trtu_kind_t       kind;
		logic [IDX_W-1:0] timer;
	} trtu_dec_t;

	typedef struct packed {
		logic              valid;
		logic              write;
		logic [1:0]        size;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} trtu_req_t;

	typedef struct packed {
		logic              ack;
		logic              err;
		logic [DATA_W-1:0] rdata;
	} trtu_rsp_t;

endpackage

`default_nettype wire

// ==== trtu_timer_unit_end.sv ====
// trtu_timer_unit_end: intentionally empty compile unit marker.
// assumes nothing.
`default_nettype none
`default_nettype wire

// ==== trtu_timer_unit_chk.sv ====
// trtu_timer_unit_chk: port-level assertions for the timer unit.
// assumes it is bound to trtu_timer_unit and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module trtu_timer_unit_chk (
	input wire logic                            clk,
	input wire logic                            reset,
	input wire logic [trtu_pkg::BASE_HI_W-1:0]  base_addr_hi,
	input wire trtu_pkg::trtu_req_t             req,
	input wire trtu_pkg::trtu_rsp_t             rsp,
	input wire logic [trtu_pkg::NUM_TIMERS-1:0] timer_irq
);
	logic [19:0] off;
	logic        hit;
	logic        word;
	logic        legal;
	logic        ctl;
	logic        wr_ctl0;
	assign off = req.addr[19:0];
	assign hit = req.valid && req.addr[31:20] == base_addr_hi;
	assign word = req.size == trtu_pkg::SIZE_WORD;
	assign legal = hit && word && off[2:0] == 3'h0 && off >= 20'h0_0200 && off <= 20'h0_0248;
	assign ctl = off == 20'h0_0210 || off == 20'h0_0228 || off == 20'h0_0240;
	assign wr_ctl0 = legal && req.write && off == 20'h0_0210;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_req_gets_ack: assert property (req.valid |=> rsp.ack)
		else $error("request without answer");
	a_idle_no_ack: assert property (!req.valid |=> !rsp.ack)
		else $error("answer without request");
	a_size_error: assert property (req.valid && !word |=> rsp.err && rsp.rdata == 32'h0000_0000)
		else $error("non-word transfer accepted");
	a_base_error: assert property (req.valid && !hit |=> rsp.err)
		else $error("foreign base accepted");
	a_map_error: assert property (hit && word && !legal |=> rsp.err)
		else $error("unmapped offset accepted");
	a_legal_no_err: assert property (legal |=> !rsp.err)
		else $error("mapped word access refused");
	a_ctrl_reserved: assert property (legal && !req.write && ctl |=> rsp.rdata[31:3] == 29'h0)
		else $error("control reserved bits read nonzero");
	a_div_width: assert property (legal && !req.write && off == 20'h0_0248 |=> rsp.rdata[31:16] == 16'h0000)
		else $error("prescaler upper bits read nonzero");
	a_irq_gated: assert property (wr_ctl0 && !req.wdata[1] ##1 !wr_ctl0 |=> !timer_irq[0])
		else $error("interrupt with enable clear");
	c_store: cover property (legal && req.write);
	c_refused: cover property (req.valid && !legal);
	c_irq: cover property ($rose(timer_irq[0]));
endmodule
bind trtu_timer_unit trtu_timer_unit_chk chk (.clk(clk), .reset(reset), .base_addr_hi(base_addr_hi),
	.req(req), .rsp(rsp), .timer_irq(timer_irq));
`default_nettype wire

// ==== trtu_core_model.sv ====
// trtu_core_model: processor side issuing loads and stores of any transfer size.
// assumes an answer within a few cycles of each request.
`timescale 1ns/10ps
`default_nettype none
module trtu_core_model (
	input  wire logic                clk,
	output trtu_pkg::trtu_req_t      req,
	input  wire trtu_pkg::trtu_rsp_t rsp
);
	initial req = '0;
	task automatic xfer(input logic w, input logic [1:0] sz, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		int i;
		@(posedge clk);
		req <= '{valid: 1'b1, write: w, size: sz, addr: a, wdata: wd};
		@(posedge clk);
		// released lines show garbage, not the last value
		req <= '{valid: 1'b0, write: ~w, size: ~sz, addr: ~a, wdata: ~wd};
		rd = '1;
		er = 1'b1;
		for (i = 0; i < 4; i++) begin
			@(negedge clk);
			if (rsp.ack === 1'b1) begin
				rd = rsp.rdata;
				er = rsp.err;
				break;
			end
		end
	endtask
endmodule
`default_nettype wire

// ==== tb_triple_reload_timer_unit.sv ====
// tb_triple_reload_timer_unit: self-checking bench for the timer unit.
// assumes the core model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_triple_reload_timer_unit;
	logic                clk;
	logic                reset;
	logic [11:0]         base;
	trtu_pkg::trtu_req_t req;
	trtu_pkg::trtu_rsp_t rsp;
	logic [2:0]          irq;
	int                  n_fail;
	int                  tests_run;
	int                  cyc;
	logic [31:0]         rd;
	logic                er;
	trtu_core_model core (.clk(clk), .req(req), .rsp(rsp));
	trtu_timer_unit uut (.clk(clk), .reset(reset), .base_addr_hi(base), .req(req), .rsp(rsp),
		.timer_irq(irq));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail = n_fail + 1;
			summarize();
		end
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic acc(input logic w, input logic [1:0] sz, input logic [19:0] off,
		input logic [31:0] wd);
		core.xfer(w, sz, {base, off}, wd, rd, er);
	endtask
	task automatic wr(input logic [19:0] off, input logic [31:0] wd);
		acc(1'b1, trtu_pkg::SIZE_WORD, off, wd);
		check("store err", {31'h0, er}, 32'h0000_0000);
	endtask
	task automatic rdchk(input string nm, input logic [19:0] off, input logic [31:0] exp);
		acc(1'b0, trtu_pkg::SIZE_WORD, off, 32'h0000_0000);
		check(nm, rd, exp);
	endtask
	task automatic wait_irq(input int n, output int t);
		int i;
		t = -1;
		for (i = 0; i < 200; i++) begin
			@(negedge clk);
			if (irq[n] === 1'b1) begin
				t = cyc;
				break;
			end
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		int n, d, r, t1, t2;
		logic [19:0] c;
		logic [31:0] v;
		reset = 1'b1;
		cyc = 0;
		n_fail = 0;
		tests_run = 0;
		void'($urandom(49));
		base = 12'($urandom());
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		for (n = 0; n < 10; n++) rdchk("reset value", 20'h0_0200 + 20'(n * 8), 32'h0000_0000);
		check("irq idle", {29'h0, irq}, 32'h0000_0000);
		$display("test reset done");
		for (n = 0; n < 6; n++) begin
			c = (n == 3) ? 20'h0_0204 : (n == 4) ? 20'h0_0250 : 20'h0_01F8;
			acc(1'b1, (n < 3) ? 2'(n + n / 2) : trtu_pkg::SIZE_WORD, (n < 3) ? 20'h0_0200 : c, '1);
			check("refused err", {31'h0, er}, 32'h0000_0001);
		end
		core.xfer(1'b0, trtu_pkg::SIZE_WORD, {base ^ 12'h001, 20'h0_0200}, '0, rd, er);
		check("foreign base", {er, rd[30:0]}, 32'h8000_0000);
		rdchk("refused store", 20'h0_0200, 32'h0000_0000);
		$display("test refusals done");
		for (n = 0; n < 3; n++) begin
			v = $urandom();
			wr(20'h0_0200 + 20'(n * 24), v);
			rdchk("reload rw", 20'h0_0200 + 20'(n * 24), v);
			wr(20'h0_0208 + 20'(n * 24), ~v);
			rdchk("count rw", 20'h0_0208 + 20'(n * 24), ~v);
		end
		wr(20'h0_0248, 32'hFFFF_ABCD);
		rdchk("prescaler width", 20'h0_0248, 32'h0000_ABCD);
		// boot setting: 40 clocks of 25 ns give one tick per microsecond
		wr(20'h0_0248, 32'h0000_0027);
		rdchk("boot prescaler", 20'h0_0248, 32'h0000_0027);
		wr(20'h0_0210, 32'hFFFF_FFF8);
		rdchk("control reserved", 20'h0_0210, 32'h0000_0000);
		$display("test registers done");
		for (n = 0; n < 3; n++) begin
			d = (n == 0) ? 0 : $urandom_range(2, 0);
			r = (n == 0) ? 9 : $urandom_range(14, 9);
			c = 20'h0_0210 + 20'(n * 24);
			wr(20'h0_0248, 32'(d));
			wr(c - 20'h0_0010, 32'(r));
			wr(c - 20'h0_0008, 32'h0000_0000);
			wr(c, 32'h0000_0003);
			wait_irq(n, t1);
			check("other irqs", {29'h0, irq & ~(3'h1 << n)}, 32'h0000_0000);
			wr(c, 32'h0000_0001);
			check("irq gated", {31'h0, irq[n]}, 32'h0000_0000);
			rdchk("status held", c, 32'h0000_0005);
			wr(c, 32'h0000_0007);
			check("irq cleared", {31'h0, irq[n]}, 32'h0000_0000);
			wait_irq(n, t2);
			check("period", 32'(t2 - t1), 32'((r + 1) * (d + 1)));
			wr(c, 32'h0000_0004);
			acc(1'b0, trtu_pkg::SIZE_WORD, c - 20'h0_0008, 32'h0000_0000);
			v = rd;
			repeat (5) @(posedge clk);
			rdchk("count frozen", c - 20'h0_0008, v);
			$display("test timer %0d done", n);
		end
		summarize();
	end
endmodule
`default_nettype wire
